// file: verilog/tpc_pkg.sv
// Purpose: constants for the two-phase pulse event counter channel
// Assumes: 32-bit APB, one aligned word per register
// Notes: offsets and field positions shared by all design files
// Behaviour
// RQ1: in this mode count events come only from the two pin pulses
// RQ2: count direction follows the pin phase relation, never a software bit
// RQ3: reload mode reloads on wrap and continues; free-run does not reload
// RQ4: set value n divides by ffff-n+1 counting up, n+1 counting down
// RQ5: counting begins when software sets the start flag
// RQ6: clearing the start flag halts counting and holds the count
// RQ7: every overflow or underflow raises an interrupt request
// RQ8: software sets both pin port directions to input before use
// RQ9: reading the timer register returns the live counter value
// RQ10: timer write while stopped loads reload register and counter
// RQ11: timer write while counting loads reload only; counter at next reload
// RQ12: normal: up on input rise, down on input fall, only while output high
// RQ13: x4: input rising while output high, count up on every edge
// RQ14: x4: input falling while output high, count down on every edge
// RQ15: only channel three selects mode; two fixed normal, four fixed x4
// RQ16: two-phase counting exists only on channels two, three and four
// RQ17: pins of channels one and two have no general port function
// RQ18: count type bit: 0 reload operation, 1 free-run operation
// RQ19: processing select bit: 0 normal, 1 x4, effective on channel three only
// RQ20: operation mode field 01 selects event counter mode
// RQ21: counter and reload are 16 bits; pins synchronised before detection
`default_nettype none
package tpc_pkg;
  localparam int TPC_CNT_W = 16;
  localparam int TPC_ADDR_W = 8;
  localparam int TPC_SYNC_STAGES = 2;
  // register byte addresses
  localparam logic [7:0] TPC_OFF_MODE = 8'h00;
  localparam logic [7:0] TPC_OFF_TIMER = 8'h04;
  localparam logic [7:0] TPC_OFF_START = 8'h08;
  localparam logic [7:0] TPC_OFF_STATUS = 8'h0c;
  localparam logic [7:0] TPC_OFF_RELOAD = 8'h10;
  // mode register layout
  localparam int TPC_MODE_OP_LSB = 0;
  localparam int TPC_MODE_CT_BIT = 6;
  localparam int TPC_MODE_QP_BIT = 7;
  localparam logic [1:0] TPC_OP_EVENT = 2'h1;
  localparam logic [7:0] TPC_MODE_RST = 8'h00;
  // start register layout
  localparam int TPC_START_BIT = 0;
  // status register layout
  localparam int TPC_ST_RUN = 0;
  localparam int TPC_ST_DIR_UP = 1;
  localparam int TPC_ST_X4 = 2;
  localparam int TPC_ST_QUAD_OK = 3;
  localparam int TPC_ST_X4_SEL = 4;
  localparam int TPC_ST_PORT_FN = 5;
  // reset values
  localparam logic [15:0] TPC_CNT_RST = 16'h0000;
  localparam logic [15:0] TPC_RELOAD_RST = 16'h0000;
  // apb phase of the slave
  typedef enum logic {TPC_APB_IDLE, TPC_APB_ACCESS} tpc_apb_e;
endpackage
`default_nettype wire

// file: verilog/tpc_phase_decoder.sv
// Purpose: synchronise the two pins and turn edges into up/down pulses
// Assumes: pins change slower than two pclk cycles
// Notes: pulses are one cycle, never both at once
`default_nettype none
module tpc_phase_decoder
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_pin,
  input wire logic out_pin,
  input wire logic mult4,
  output logic count_up,
  output logic count_down
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;
  logic in_rise;
  logic in_fall;
  logic one_change;
  logic x4_up;

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
    end
    else
    begin
      meta_r <= {in_pin, out_pin};
      sync_r <= meta_r; // [RQ21]
    end
  end

  // previous synced state for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_r <= 2'h0;
    else
      prev_r <= sync_r;
  end

  assign in_rise = sync_r[1] & ~prev_r[1];
  assign in_fall = ~sync_r[1] & prev_r[1];
  // a double change is a glitch or overspeed and is dropped in x4 mode
  assign one_change = ^(sync_r ^ prev_r);
  // up order (in,out): 01 11 10 00; old input xor new output says up
  assign x4_up = prev_r[1] ^ sync_r[0]; // [RQ2]

  // registered direction pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_up <= 1'b0;
      count_down <= 1'b0;
    end
    else if (mult4)
    begin
      count_up <= one_change & x4_up; // [RQ13]
      count_down <= one_change & ~x4_up; // [RQ14]
    end
    else
    begin
      count_up <= in_rise & sync_r[0]; // [RQ12]
      count_down <= in_fall & sync_r[0]; // [RQ12]
    end
  end
endmodule
`default_nettype wire

// file: verilog/tpc_counter.sv
// Purpose: two-phase pulse event counter channel with APB registers
// Assumes: pins are inputs driven by an external encoder
// Notes: zero-wait APB slave; read data captured in the setup cycle
//
// Our own choices: the APB register port and the register addresses.
`default_nettype none
module tpc_counter
  import tpc_pkg::*;
#(
  parameter int CHAN_ID = 3,
  parameter int CNT_W = TPC_CNT_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  input wire logic timer_output_pin,
  output logic count_wrap_irq,
  output logic counting
);
  import tpc_pkg::*;

  // channel capabilities fixed at build time
  localparam bit QUAD_OK = (CHAN_ID >= 2) && (CHAN_ID <= 4); // [RQ16]
  localparam bit X4_SEL = (CHAN_ID == 3); // [RQ15]
  localparam bit X4_FIXED = (CHAN_ID == 4); // [RQ15]
  localparam bit PORT_FN = (CHAN_ID != 1) && (CHAN_ID != 2); // [RQ17]
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // address match on an aligned word
  function automatic logic addr_is(input logic [TPC_ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  // full lanes needed for a field to take a write
  function automatic logic lanes_ok(input logic [3:0] s, input int n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (i < n)
        ok = ok & s[i];
    end
    lanes_ok = ok;
  endfunction

  tpc_apb_e apb_r;
  logic [7:0] mode_r;
  logic start_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] reload_r;
  logic [CNT_W-1:0] reload_src;
  logic dir_up_r;
  logic ev_up;
  logic ev_down;
  logic dec_up;
  logic dec_down;
  logic run;
  logic mult4;
  logic free_run;
  logic wrap;
  logic setup;
  logic wr_acc;
  logic known;
  logic wr_timer;
  logic wr_mode;
  logic wr_start;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  // mode decode from the mode register
  assign free_run = mode_r[TPC_MODE_CT_BIT]; // [RQ18]
  assign mult4 = X4_FIXED | (X4_SEL & mode_r[TPC_MODE_QP_BIT]); // [RQ19]
  assign run = start_r & QUAD_OK
             & (mode_r[TPC_MODE_OP_LSB +: 2] == TPC_OP_EVENT); // [RQ20]

  // edge and phase detection on the pins
  tpc_phase_decoder u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .in_pin(timer_input_pin),
    .out_pin(timer_output_pin),
    .mult4(mult4),
    .count_up(dec_up),
    .count_down(dec_down)
  );

  // only pin pulses count, and only while running
  assign ev_up = run & dec_up; // [RQ1] [RQ5]
  assign ev_down = run & dec_down; // [RQ1] [RQ6]
  assign wrap = (ev_up & (cnt_r == CNT_MAX))
              | (ev_down & (cnt_r == CNT_ZERO)); // [RQ4]

  // apb strobes; writes land at the access edge
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign wr_timer = wr_acc & addr_is(paddr, TPC_OFF_TIMER)
                  & lanes_ok(pstrb, CNT_W / 8);
  assign wr_mode = wr_acc & addr_is(paddr, TPC_OFF_MODE) & pstrb[0];
  assign wr_start = wr_acc & addr_is(paddr, TPC_OFF_START) & pstrb[0];

  // a write in the same cycle as a wrap is the value reloaded
  assign reload_src = wr_timer ? pwdata[CNT_W-1:0] : reload_r;

  // apb phase tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      apb_r <= TPC_APB_IDLE;
    else
    begin
      unique case (apb_r)
        TPC_APB_IDLE:
        begin
          if (setup)
            apb_r <= TPC_APB_ACCESS;
        end
        TPC_APB_ACCESS:
        begin
          if (setup)
            apb_r <= TPC_APB_ACCESS;
          else
            apb_r <= TPC_APB_IDLE;
        end
      endcase
    end
  end

  // mode register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= TPC_MODE_RST;
    else if (wr_mode)
      mode_r <= pwdata[7:0];
  end

  // count start flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_r <= 1'b0;
    else if (wr_start)
      start_r <= pwdata[TPC_START_BIT]; // [RQ5] [RQ6]
  end

  // reload register takes every timer write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_r <= TPC_RELOAD_RST;
    else if (wr_timer)
      reload_r <= pwdata[CNT_W-1:0]; // [RQ10] [RQ11]
  end

  // next counter value
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (wr_timer & ~run)
      cnt_nxt = pwdata[CNT_W-1:0]; // [RQ10]
    else if (wrap & ~free_run)
      cnt_nxt = reload_src; // [RQ3] [RQ11]
    else if (ev_up)
      cnt_nxt = cnt_r + 1'b1; // free-run wraps to zero [RQ3]
    else if (ev_down)
      cnt_nxt = cnt_r - 1'b1; // free-run wraps to all ones [RQ3]
  end

  // counter; holds when stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= TPC_CNT_RST;
    else
      cnt_r <= cnt_nxt; // [RQ6]
  end

  // last seen direction, for software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_up_r <= 1'b0;
    else if (ev_up | ev_down)
      dir_up_r <= ev_up; // [RQ2]
  end

  // interrupt request pulse on every wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_wrap_irq <= 1'b0;
    else
      count_wrap_irq <= wrap; // [RQ7]
  end

  // running indication
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counting <= 1'b0;
    else
      counting <= run;
  end

  // status word: live state and channel capabilities
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[TPC_ST_RUN] = run;
    status_word[TPC_ST_DIR_UP] = dir_up_r;
    status_word[TPC_ST_X4] = mult4;
    status_word[TPC_ST_QUAD_OK] = QUAD_OK;
    status_word[TPC_ST_X4_SEL] = X4_SEL;
    status_word[TPC_ST_PORT_FN] = PORT_FN;
  end

  // read mux and address check
  always_comb
  begin
    rd_word = 32'h0000_0000;
    known = 1'b1;
    if (addr_is(paddr, TPC_OFF_MODE))
      rd_word[7:0] = mode_r;
    else if (addr_is(paddr, TPC_OFF_TIMER))
      rd_word[CNT_W-1:0] = cnt_nxt; // [RQ9]
    else if (addr_is(paddr, TPC_OFF_START))
      rd_word[TPC_START_BIT] = start_r;
    else if (addr_is(paddr, TPC_OFF_STATUS))
      rd_word = status_word;
    else if (addr_is(paddr, TPC_OFF_RELOAD))
      rd_word[CNT_W-1:0] = reload_r;
    else
      known = 1'b0;
  end

  // ready for exactly the first access cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // error answer for unmapped addresses, captured in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (setup)
      pslverr <= ~known;
    else
      pslverr <= 1'b0;
  end

  // read data captured in setup; the counter value is the one
  // it takes at that edge, so a pin event in the access cycle
  // shows on the next read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup & ~pwrite)
      prdata <= rd_word; // [RQ9]
    else if (setup)
      prdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// file: tb/tpc_counter_properties.sv
// Purpose: port-level checks of the two-phase counter channel
// Assumes: zero-wait apb slave with one access cycle
// Notes: bound onto every tpc_counter instance
`default_nettype none
module tpc_counter_properties
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_pin,
  input wire logic timer_output_pin,
  input wire logic count_wrap_irq,
  input wire logic counting
);
  logic in_q;
  logic out_q;
  logic [3:0] quiet_r;
  logic wr_acc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since a pin last moved, saturating; a wrap needs recent pin activity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_q <= 1'b0;
      out_q <= 1'b0;
      quiet_r <= 4'hf;
    end
    else
    begin
      in_q <= timer_input_pin;
      out_q <= timer_output_pin;
      quiet_r <= (timer_input_pin != in_q || timer_output_pin != out_q) ? 4'h0 :
        quiet_r + {3'h0, quiet_r != 4'hf};
    end
  end
  assign wr_acc = psel && penable && pready && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_once: assert property (s_access |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (s_access and paddr > TPC_OFF_RELOAD |-> pslverr)
    else $error("unmapped access without error");
  a_upper_zero: assert property (s_access and !pwrite && paddr == TPC_OFF_TIMER
    |-> prdata[31:16] == 16'h0000)
    else $error("timer read upper half not zero");
  a_irq_pulse: assert property (count_wrap_irq |=> !count_wrap_irq)
    else $error("wrap request longer than one cycle");
  a_irq_from_pins: assert property (count_wrap_irq |-> quiet_r < 4'hc)
    else $error("wrap without pin activity");
  a_irq_when_on: assert property (count_wrap_irq |-> counting || $past(counting)
    || $past(counting, 2))
    else $error("wrap while stopped");
  a_start_cause: assert property ($rose(counting) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("counting started without a write");
  a_stop_cause: assert property ($fell(counting) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("counting stopped without a write");
endmodule
bind tpc_counter tpc_counter_properties tpc_counter_properties_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
  .count_wrap_irq(count_wrap_irq), .counting(counting));
`default_nettype wire

// file: tb/tpc_encoder.sv
// Purpose: quadrature source standing in for the external encoder
// Assumes: both channel pins are inputs on the device side
// Notes: move walks whole cycles, so normal and x4 modes end in step
`default_nettype none
module tpc_encoder
(
  input wire logic pclk,
  output logic enc_in,
  output logic enc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos_r = 2'h0;
  // walk 01 11 10 00: which pin leads gives the direction
  assign enc_in = pos_r[0] ^ pos_r[1];
  assign enc_out = ~pos_r[1];
  // levels hold hold+1 clocks so the synchroniser never misses a step
  task automatic move(input logic up, input int cycles, input int hold);
    repeat (4 * cycles)
    begin
      @(posedge pclk);
      pos_r <= up ? pos_r + 2'h1 : pos_r - 2'h1;
      repeat (hold) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/test_two_phase_pulse_event_counter.sv
// Purpose: self-checking bench for the two-phase counter channel
// Assumes: channel three, pins driven by tpc_encoder
// Notes: ordinary cases in a row table, awkward ones written out after
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_two_phase_pulse_event_counter import tpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] mode; logic [15:0] n; logic up; int cyc; logic [15:0] ex;
    int irqs;} tpc_row_s;
  // mode, set value, direction, encoder cycles, final count, wraps
  tpc_row_s rows [9] = '{'{8'h01, 16'h0010, 1'b1, 5, 16'h0015, 0},
    '{8'h01, 16'h0010, 1'b0, 3, 16'h000d, 0}, '{8'h81, 16'h0100, 1'b1, 2, 16'h0108, 0},
    '{8'h81, 16'h0100, 1'b0, 1, 16'h00fc, 0}, '{8'h01, 16'hfffe, 1'b1, 3, 16'hffff, 1},
    '{8'h01, 16'h0001, 1'b0, 5, 16'h0000, 2}, '{8'h41, 16'hfffe, 1'b1, 3, 16'h0001, 1},
    '{8'h00, 16'h0005, 1'b1, 3, 16'h0005, 0}, '{8'h81, 16'h0002, 1'b0, 1, 16'h0001, 1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic irq;
  logic cnt_on;
  wire logic in_pin;
  wire logic out_pin;
  int miscompares = 0;
  int tests_run = 0;
  int irq_seen = 0;
  int cycles = 0;
  tpc_counter tpc_counter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(in_pin),
    .timer_output_pin(out_pin), .count_wrap_irq(irq), .counting(cnt_on));
  tpc_encoder tpc_encoder_inst (.pclk(pclk), .enc_in(in_pin), .enc_out(out_pin));
  always #5 pclk = ~pclk;
  // wrap pulses are counted; the cycle ceiling cuts a hang short
  always @(posedge pclk)
  begin
    if (irq === 1'b1)
      irq_seen++;
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("read data", ex, rd)
  endtask
  task automatic spin(input logic up, input int cyc);
    tpc_encoder_inst.move(up, cyc, 2);
    repeat (8) @(posedge pclk);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(TPC_OFF_TIMER, 32'h0);
    rd_chk(TPC_OFF_MODE, 32'h0);
    // channel three: two-phase capable, x4 selectable, pins keep a port function
    rd_chk(TPC_OFF_STATUS, 32'h38);
    foreach (rows[i])
    begin
      apb(1'b1, TPC_OFF_START, 32'h0);
      apb(1'b1, TPC_OFF_MODE, {24'h0, rows[i].mode});
      apb(1'b1, TPC_OFF_TIMER, {16'h0, rows[i].n});
      apb(1'b1, TPC_OFF_START, 32'h1);
      irq_seen = 0;
      repeat (2) @(posedge pclk);
      `CHK("counting", rows[i].mode[1:0] == TPC_OP_EVENT, cnt_on)
      tpc_encoder_inst.move(rows[i].up, rows[i].cyc, 2 + i);
      repeat (8) @(posedge pclk);
      rd_chk(TPC_OFF_TIMER, {16'h0, rows[i].ex});
      `CHK("wraps", rows[i].irqs, irq_seen)
    end
    // running write reaches the reload only, counter picks it up at the wrap
    apb(1'b1, TPC_OFF_START, 32'h0);
    apb(1'b1, TPC_OFF_MODE, 32'h01);
    apb(1'b1, TPC_OFF_TIMER, 32'hfffe);
    apb(1'b1, TPC_OFF_START, 32'h1);
    apb(1'b1, TPC_OFF_TIMER, 32'h1234);
    rd_chk(TPC_OFF_TIMER, 32'hfffe);
    rd_chk(TPC_OFF_RELOAD, 32'h1234);
    spin(1'b1, 2);
    rd_chk(TPC_OFF_TIMER, 32'h1234);
    // stopped channel ignores pins, and a write lands in the counter at once
    apb(1'b1, TPC_OFF_START, 32'h0);
    spin(1'b1, 2);
    rd_chk(TPC_OFF_TIMER, 32'h1234);
    apb(1'b1, TPC_OFF_TIMER, 32'h00aa);
    rd_chk(TPC_OFF_TIMER, 32'h00aa);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
